// ==== design/adcs_defs.vh ====
// register map, field positions, reset values and codes of the sequencer
`ifndef ADCS_DEFS_VH
`define ADCS_DEFS_VH

// register indices; the byte address is four times the index
`define ADCS_IDX_RESULT     18'h05380
`define ADCS_IDX_TRIGGER    18'h05382
`define ADCS_IDX_CONTROL    18'h05384
`define ADCS_IDX_CLOCK      18'h05386

// trigger/channel register fields
`define ADCS_TRG_END_HI     13
`define ADCS_TRG_END_LO     11
`define ADCS_TRG_START_HI   10
`define ADCS_TRG_START_LO   8
`define ADCS_TRG_ALIGN      7
`define ADCS_TRG_MODE       6
`define ADCS_TRG_SRC_HI     5
`define ADCS_TRG_SRC_LO     4
`define ADCS_TRG_SAMP_HI    2
`define ADCS_TRG_SAMP_LO    0
`define ADCS_TRG_SAMP_RST   3'h7

// control register fields
`define ADCS_CTL_ENABLE     0
`define ADCS_CTL_RUN        1
`define ADCS_CTL_DONE       2
`define ADCS_CTL_OVWR       3
`define ADCS_CTL_DONE_IE    4
`define ADCS_CTL_OVWR_IE    5
`define ADCS_CTL_BUSY       6
`define ADCS_CTL_CHAN_HI    10
`define ADCS_CTL_CHAN_LO    8

// trigger source codes
`define ADCS_SRC_SOFTWARE   2'h0
`define ADCS_SRC_TIMER      2'h1
`define ADCS_SRC_EXTERNAL   2'h3

// bus answers
`define ADCS_RESP_OKAY      2'h0
`define ADCS_RESP_SLVERR    2'h2

`endif

// ==== design/adcs_fall_det.v ====
// falling edge detector for the external trigger pin
`timescale 1ns/1ps
module adcs_fall_det (
  input  wire aclk,
  input  wire aresetn,
  input  wire level_in,
  output reg  fall_pulse_r
);
  reg level_d_r;

  // remember last level; pulse one cycle after a high-to-low change
  always @(posedge aclk) begin
    if (!aresetn) begin
      level_d_r    <= 1'b1;
      fall_pulse_r <= 1'b0;
    end else begin
      level_d_r    <= level_in;
      fall_pulse_r <= level_d_r & ~level_in;
    end
  end
endmodule

// ==== design/adcs_seq.v ====
// conversion sequencer with axi4-lite registers for a 10-bit adc
//
// Behaviour
// - start only on trigger while enabled
// - software run write starts in software mode
// - only the selected trigger source counts
// - sequence begins at start channel
// - run bit reads one while busy
// - active channel index readable
// - finished result loaded, completion flag set
// - step automatically to following channels
// - completion interrupt with result store
// - result read clears completion flag
// - finish while flag set: overwrite, error
// - overwrite raises error interrupt request
// - error flag cleared only by writing one
// - overwrite never disturbs channel stepping
// - one-time mode stops after end channel
// - continuous mode restarts at start channel
// - writing zero to run aborts, discards
// - start above end wraps through zero
// - enable readies triggers; clear to reconfigure
// - external trigger on falling pin edge
// - each interrupt cause gated by enable
`timescale 1ns/1ps
`include "adcs_defs.vh"
module adcs_seq #(
  parameter ADDR_W = 20,
  parameter DATA_W = 10
) (
  input  wire              aclk,
  input  wire              aresetn,
  // axi4-lite slave
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  // trigger sources
  input  wire              timer_underflow,
  input  wire              external_trigger_input,
  // analog sampling core
  output reg               conv_start_r,
  output reg               conv_abort_r,
  output reg  [2:0]        conv_channel_r,
  output reg  [2:0]        sample_time_r,
  input  wire              conv_done,
  input  wire [DATA_W-1:0] conv_data,
  // shared request to the interrupt controller unit
  output reg               adc_irq_r
);
  localparam ST_IDLE  = 2'h0;
  localparam ST_START = 2'h1;
  localparam ST_WAIT  = 2'h2;
  localparam PAD_W    = 16 - DATA_W;

  // register word indices seen on the bus
  localparam [ADDR_W-3:0] IDX_RES = `ADCS_IDX_RESULT;
  localparam [ADDR_W-3:0] IDX_TRG = `ADCS_IDX_TRIGGER;
  localparam [ADDR_W-3:0] IDX_CTL = `ADCS_IDX_CONTROL;
  localparam [ADDR_W-3:0] IDX_CLK = `ADCS_IDX_CLOCK;

  // trigger/channel register and clock-control word
  reg [2:0]        end_channel_select_r;
  reg [2:0]        start_channel_select_r;
  reg              align_left_r;
  reg              repeat_mode_select_r;
  reg [1:0]        trigger_source_select_r;
  reg [15:0]       clock_ctl_r;
  // control register and result register
  reg              converter_enable_r;
  reg              completion_flag_r;
  reg              overwrite_error_flag_r;
  reg              completion_irq_enable_r;
  reg              overwrite_irq_enable_r;
  reg [15:0]       result_reg_r;
  // sequencer
  reg [1:0]        state_r;
  reg [2:0]        active_channel_index_r;
  // write channel holding
  reg              aw_held_r;
  reg              w_held_r;
  reg [ADDR_W-3:0] wr_idx_r;
  reg [31:0]       wr_data_r;
  reg [3:0]        wr_strb_r;

  wire ext_fall;

  adcs_fall_det u_fall (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .level_in     (external_trigger_input),
    .fall_pulse_r (ext_fall)
  );

  // bus event decode
  wire aw_hs   = s_axi_awvalid & s_axi_awready;
  wire w_hs    = s_axi_wvalid & s_axi_wready;
  wire wr_go   = aw_held_r & w_held_r & ~s_axi_bvalid;
  wire ar_hs   = s_axi_arvalid & s_axi_arready;
  wire [ADDR_W-3:0] rd_idx = s_axi_araddr[ADDR_W-1:2];
  wire wr_ctl  = wr_go & (wr_idx_r == IDX_CTL) & wr_strb_r[0];
  wire wr_ctl1 = wr_go & (wr_idx_r == IDX_CTL) & wr_strb_r[1];
  wire wr_trg0 = wr_go & (wr_idx_r == IDX_TRG) & wr_strb_r[0];
  wire wr_trg1 = wr_go & (wr_idx_r == IDX_TRG) & wr_strb_r[1];
  wire wr_clk0 = wr_go & (wr_idx_r == IDX_CLK) & wr_strb_r[0];
  wire wr_clk1 = wr_go & (wr_idx_r == IDX_CLK) & wr_strb_r[1];
  wire wr_map  = (wr_idx_r == IDX_RES) | (wr_idx_r == IDX_TRG) |
                 (wr_idx_r == IDX_CTL) | (wr_idx_r == IDX_CLK);
  wire rd_map  = (rd_idx == IDX_RES) | (rd_idx == IDX_TRG) |
                 (rd_idx == IDX_CTL) | (rd_idx == IDX_CLK);

  wire busy     = (state_r != ST_IDLE);
  wire run_wr1  = wr_ctl & wr_data_r[`ADCS_CTL_RUN];
  wire run_wr0  = wr_ctl & ~wr_data_r[`ADCS_CTL_RUN];
  wire en_now   = wr_ctl ? wr_data_r[`ADCS_CTL_ENABLE] : converter_enable_r;

  // pick the one trigger source software selected
  reg trig_sel;
  always @* begin
    case (trigger_source_select_r)
      `ADCS_SRC_SOFTWARE: trig_sel = run_wr1;
      `ADCS_SRC_TIMER:    trig_sel = timer_underflow;
      `ADCS_SRC_EXTERNAL: trig_sel = ext_fall;
      default:            trig_sel = 1'b0;
    endcase
  end

  // a trigger starts only when enabled and idle
  wire trig_ok  = trig_sel & en_now & ~busy;
  // software stop, or losing the enable, ends a running sequence
  wire abort    = busy & (run_wr0 | ~en_now);
  wire finish   = (state_r == ST_WAIT) & conv_done & ~abort;
  wire last_ch  = (active_channel_index_r == end_channel_select_r);
  wire res_read = ar_hs & (rd_idx == IDX_RES);

  // aligned result word
  wire [15:0] conv_word = align_left_r ?
    {conv_data, {PAD_W{1'b0}}} : {{PAD_W{1'b0}}, conv_data};

  // sequencer state, channel stepping and analog core strobes
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_r                <= ST_IDLE;
      active_channel_index_r <= 3'h0;
      conv_start_r           <= 1'b0;
      conv_abort_r           <= 1'b0;
      conv_channel_r         <= 3'h0;
    end else begin
      conv_start_r <= 1'b0;
      conv_abort_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (trig_ok) begin
            active_channel_index_r <= start_channel_select_r;
            state_r                <= ST_START;
          end
        end
        ST_START: begin
          if (abort) begin
            state_r      <= ST_IDLE;
            conv_abort_r <= 1'b1;
          end else begin
            conv_start_r   <= 1'b1;
            conv_channel_r <= active_channel_index_r;
            state_r        <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (abort) begin
            state_r      <= ST_IDLE;
            conv_abort_r <= 1'b1;
          end else if (finish) begin
            if (last_ch && !repeat_mode_select_r) begin
              state_r <= ST_IDLE;
            end else if (last_ch) begin
              active_channel_index_r <= start_channel_select_r;
              state_r                <= ST_START;
            end else begin
              // 3-bit add wraps seven to zero
              active_channel_index_r <=
                active_channel_index_r + 3'h1;
              state_r                <= ST_START;
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // result register and status flags; a set beats a clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      result_reg_r           <= 16'h0000;
      completion_flag_r      <= 1'b0;
      overwrite_error_flag_r <= 1'b0;
    end else begin
      if (finish) begin
        result_reg_r      <= conv_word;
        completion_flag_r <= 1'b1;
      end else if (res_read) begin
        completion_flag_r <= 1'b0;
      end
      if (finish && completion_flag_r) begin
        overwrite_error_flag_r <= 1'b1;
      end else if (wr_ctl && wr_data_r[`ADCS_CTL_OVWR]) begin
        overwrite_error_flag_r <= 1'b0;
      end
    end
  end

  // software-written configuration
  always @(posedge aclk) begin
    if (!aresetn) begin
      end_channel_select_r    <= 3'h0;
      start_channel_select_r  <= 3'h0;
      align_left_r            <= 1'b0;
      repeat_mode_select_r    <= 1'b0;
      trigger_source_select_r <= `ADCS_SRC_SOFTWARE;
      sample_time_r           <= `ADCS_TRG_SAMP_RST;
      clock_ctl_r             <= 16'h0000;
      converter_enable_r      <= 1'b0;
      completion_irq_enable_r <= 1'b0;
      overwrite_irq_enable_r  <= 1'b0;
    end else begin
      if (wr_trg1) begin
        end_channel_select_r   <=
          wr_data_r[`ADCS_TRG_END_HI:`ADCS_TRG_END_LO];
        start_channel_select_r <=
          wr_data_r[`ADCS_TRG_START_HI:`ADCS_TRG_START_LO];
      end
      if (wr_trg0) begin
        align_left_r            <= wr_data_r[`ADCS_TRG_ALIGN];
        repeat_mode_select_r    <= wr_data_r[`ADCS_TRG_MODE];
        trigger_source_select_r <=
          wr_data_r[`ADCS_TRG_SRC_HI:`ADCS_TRG_SRC_LO];
        sample_time_r           <=
          wr_data_r[`ADCS_TRG_SAMP_HI:`ADCS_TRG_SAMP_LO];
      end
      if (wr_clk0) begin
        clock_ctl_r[7:0] <= wr_data_r[7:0];
      end
      if (wr_clk1) begin
        clock_ctl_r[15:8] <= wr_data_r[15:8];
      end
      if (wr_ctl) begin
        converter_enable_r      <= wr_data_r[`ADCS_CTL_ENABLE];
        completion_irq_enable_r <= wr_data_r[`ADCS_CTL_DONE_IE];
        overwrite_irq_enable_r  <= wr_data_r[`ADCS_CTL_OVWR_IE];
      end
    end
  end

  // shared interrupt line, each cause behind its own enable
  always @(posedge aclk) begin
    if (!aresetn) begin
      adc_irq_r <= 1'b0;
    end else begin
      adc_irq_r <= (completion_flag_r & completion_irq_enable_r) |
                   (overwrite_error_flag_r &
                    overwrite_irq_enable_r);
    end
  end

  // read data mux
  reg [15:0] rd_word;
  always @* begin
    rd_word = 16'h0000;
    if (rd_idx == IDX_RES) begin
      rd_word = result_reg_r;
    end else if (rd_idx == IDX_TRG) begin
      rd_word[`ADCS_TRG_END_HI:`ADCS_TRG_END_LO]     = end_channel_select_r;
      rd_word[`ADCS_TRG_START_HI:`ADCS_TRG_START_LO] =
        start_channel_select_r;
      rd_word[`ADCS_TRG_ALIGN]                       = align_left_r;
      rd_word[`ADCS_TRG_MODE]                        = repeat_mode_select_r;
      rd_word[`ADCS_TRG_SRC_HI:`ADCS_TRG_SRC_LO]     =
        trigger_source_select_r;
      rd_word[`ADCS_TRG_SAMP_HI:`ADCS_TRG_SAMP_LO]   = sample_time_r;
    end else if (rd_idx == IDX_CTL) begin
      rd_word[`ADCS_CTL_ENABLE]  = converter_enable_r;
      rd_word[`ADCS_CTL_RUN]     = busy;
      rd_word[`ADCS_CTL_DONE]    = completion_flag_r;
      rd_word[`ADCS_CTL_OVWR]    = overwrite_error_flag_r;
      rd_word[`ADCS_CTL_DONE_IE] = completion_irq_enable_r;
      rd_word[`ADCS_CTL_OVWR_IE] = overwrite_irq_enable_r;
      rd_word[`ADCS_CTL_BUSY]    = busy;
      rd_word[`ADCS_CTL_CHAN_HI:`ADCS_CTL_CHAN_LO] =
        active_channel_index_r;
    end else if (rd_idx == IDX_CLK) begin
      rd_word = clock_ctl_r;
    end
  end

  // write address and data are taken in either order, then answered
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `ADCS_RESP_OKAY;
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      wr_idx_r      <= {(ADDR_W-2){1'b0}};
      wr_data_r     <= 32'h00000000;
      wr_strb_r     <= 4'h0;
    end else begin
      if (aw_hs) begin
        aw_held_r     <= 1'b1;
        s_axi_awready <= 1'b0;
        wr_idx_r      <= s_axi_awaddr[ADDR_W-1:2];
      end
      if (w_hs) begin
        w_held_r     <= 1'b1;
        s_axi_wready <= 1'b0;
        wr_data_r    <= s_axi_wdata;
        wr_strb_r    <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? `ADCS_RESP_OKAY : `ADCS_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // one read at a time; data registered with the address
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `ADCS_RESP_OKAY;
    end else begin
      if (ar_hs) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {16'h0000, rd_word};
        s_axi_rresp   <= rd_map ? `ADCS_RESP_OKAY : `ADCS_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // the clock-control word only holds settings for the clock divider
  // elsewhere; it is kept so software sees a full register map
endmodule

// ==== bench/adcs_seq_props.sv ====
// port assertions for the conversion sequencer
`timescale 1ns/1ps
module adcs_seq_props #(
  parameter ADDR_W = 20,
  parameter DATA_W = 10
) (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        conv_start_r,
  input wire        conv_abort_r,
  input wire [2:0]  conv_channel_r,
  input wire        conv_done,
  input wire        adc_irq_r
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // both write channels taken on one edge
  sequence wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // start dropped again with its channel held
  sequence start_held;
    !conv_start_r && $stable(conv_channel_r);
  endsequence
  wr_answer_a: assert property (wr_both |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer late or early");
  aw_refused_a: assert property (s_axi_awvalid && s_axi_awready |=>
    !s_axi_awready) else $error("awready stayed high");
  b_stands_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  r_stands_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer moved");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read answer missing");
  resp_code_a: assert property (s_axi_rvalid |->
    s_axi_rresp == 2'h0 || s_axi_rresp == 2'h2) else $error("bad rresp");
  start_pulse_a: assert property (conv_start_r |=> start_held)
    else $error("start pulse too long");
  done_gap_a: assert property (conv_done |=> !conv_start_r)
    else $error("start right after done");
  abort_stop_a: assert property (conv_abort_r |-> !conv_start_r [*2])
    else $error("start after abort");
  reset_idle_a: assert property (disable iff (1'b0) !aresetn |=>
    s_axi_awready && !s_axi_bvalid && !conv_start_r && !adc_irq_r)
    else $error("reset values wrong");
endmodule
bind adcs_seq adcs_seq_props #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) props_i (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .conv_start_r(conv_start_r),
  .conv_abort_r(conv_abort_r), .conv_channel_r(conv_channel_r),
  .conv_done(conv_done), .adc_irq_r(adc_irq_r));

// ==== bench/adcs_core_model.sv ====
// behavioural analog core: converts after a set delay
`timescale 1ns/1ps
module adcs_core_model (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire [7:0] dly,
  input  wire       conv_start,
  input  wire       conv_abort,
  input  wire [2:0] conv_channel,
  output reg        conv_done,
  output wire [9:0] conv_data
);
  reg       busy;
  reg [7:0] cnt;
  reg [2:0] ch;
  reg [9:0] pat;
  // data valid only with done; otherwise a moving pattern
  assign conv_data = conv_done ? {ch, 7'h2A} : pat;
  // one conversion at a time, dropped on abort
  always @(posedge aclk) begin
    conv_done <= 1'b0;
    pat <= pat + 10'h155;
    if (!aresetn) begin
      busy <= 1'b0;
      pat <= 10'h000;
    end else if (conv_abort) begin
      busy <= 1'b0;
    end else if (conv_start) begin
      busy <= 1'b1;
      ch <= conv_channel;
      cnt <= dly;
    end else if (busy) begin
      if (cnt == 8'h00) begin
        busy <= 1'b0;
        conv_done <= 1'b1;
      end else cnt <= cnt - 8'h01;
    end
  end
endmodule

// ==== bench/tb_adcs_seq.sv ====
// testbench for the conversion sequencer
`timescale 1ns/1ps
`include "adcs_defs.vh"
module tb_adcs_seq;
  localparam [19:0] A_RES = {`ADCS_IDX_RESULT, 2'b00};
  localparam [19:0] A_TRG = {`ADCS_IDX_TRIGGER, 2'b00};
  localparam [19:0] A_CTL = {`ADCS_IDX_CONTROL, 2'b00};
  localparam [19:0] A_BAD = 20'h14E20;
  reg         aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  reg         tmr, ext;
  reg  [19:0] awaddr, araddr;
  reg  [31:0] wdata, v;
  reg  [7:0]  dly;
  reg  [1:0]  r;
  wire        awready, wready, bvalid, arready, rvalid;
  wire        cstart, cabort, cdone, irq;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [2:0]  cch, stime;
  wire [9:0]  cdata;
  reg  [2:0]  chq[$];
  integer     error_cnt, cmp_count, i;
  integer     cyc = 0;
  adcs_seq adcs_seq_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .timer_underflow(tmr),
    .external_trigger_input(ext), .conv_start_r(cstart),
    .conv_abort_r(cabort), .conv_channel_r(cch), .sample_time_r(stime),
    .conv_done(cdone), .conv_data(cdata), .adc_irq_r(irq));
  adcs_core_model adcs_core_model_i (.aclk(aclk), .aresetn(aresetn),
    .dly(dly), .conv_start(cstart), .conv_abort(cabort),
    .conv_channel(cch), .conv_done(cdone), .conv_data(cdata));
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // channel log and hang guard
  always @(posedge aclk) begin
    if (cstart === 1'b1) chq.push_back(cch);
    cyc = cyc + 1;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      final_report;
    end
  end
  function [31:0] dat(input [2:0] c);
    dat = {22'h0, c, 7'h2A};
  endfunction
  task chk(input [31:0] g, input [31:0] e);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task wr(input [19:0] a, input [31:0] d);
    reg ad, wd;
    begin
      ad = 1'b0;
      wd = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!ad || !wd) begin
        @(posedge aclk);
        if (!ad && awready) begin
          ad = 1'b1;
          awvalid <= 1'b0;
        end
        if (!wd && wready) begin
          wd = 1'b1;
          wvalid <= 1'b0;
        end
      end
      // answer left waiting one cycle so it must stand
      do @(posedge aclk); while (bvalid !== 1'b1);
      bready <= 1'b1;
      @(posedge aclk);
      r = bresp;
      bready <= 1'b0;
    end
  endtask
  task rd(input [19:0] a);
    begin
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rready <= 1'b1;
      @(posedge aclk);
      v = rdata;
      r = rresp;
      rready <= 1'b0;
    end
  endtask
  task idle;
    begin
      rd(A_CTL);
      while (v[1] !== 1'b0) rd(A_CTL);
    end
  endtask
  task pin_fall;
    begin
      @(posedge aclk);
      ext <= 1'b0;
      repeat (2) @(posedge aclk);
      ext <= 1'b1;
    end
  endtask
  task pulse_tmr;
    begin
      @(posedge aclk);
      tmr <= 1'b1;
      @(posedge aclk);
      tmr <= 1'b0;
    end
  endtask
  task irq_is(input e);
    begin
      repeat (2) @(posedge aclk);
      chk({31'h0, irq}, {31'h0, e});
    end
  endtask
  task final_report;
    begin
      $display("errors %0d compares %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, tmr} = 7'h00;
    {awaddr, araddr, wdata} = 72'h0;
    ext = 1'b1;
    dly = 8'h01;
    error_cnt = 0;
    cmp_count = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values and an unmapped place
    chk({29'h0, stime}, 32'h7);
    rd(A_CTL); chk(v, 32'h0);
    rd(A_TRG); chk(v, 32'h7);
    rd(A_RES); chk(v, 32'h0);
    rd(A_BAD); chk({30'h0, r}, 32'h2);
    wr(A_BAD, 32'hFFFF); chk({30'h0, r}, 32'h2);
    // run written while disabled stays idle
    wr(A_CTL, 32'h2); rd(A_CTL); chk(v, 32'h0);
    // software start 6 through wrap to 1, prompt core, no reads
    chq.delete();
    wr(A_TRG, 32'h0E07); wr(A_CTL, 32'h3); idle;
    chk(chq.size(), 4);
    for (i = 0; i < 4; i = i + 1) chk(chq[i], (6 + i) % 8);
    chk(v & 32'hFF, 32'h0D);
    wr(A_CTL, 32'h11); irq_is(1'b1);
    wr(A_CTL, 32'h21); irq_is(1'b1);
    wr(A_CTL, 32'h01); irq_is(1'b0);
    rd(A_RES); chk(v, dat(1));
    rd(A_CTL); chk(v & 32'hFF, 32'h09);
    wr(A_CTL, 32'h09); rd(A_CTL); chk(v & 32'hFF, 32'h01);
    // timer source: pin edge ignored, retrigger ignored
    dly <= 8'h14;
    chq.delete();
    wr(A_CTL, 32'h0); wr(A_TRG, 32'h1217); wr(A_CTL, 32'h1);
    pin_fall; repeat (30) @(posedge aclk);
    chk(chq.size(), 0);
    pulse_tmr; rd(A_CTL); chk(v & 32'h0702, 32'h0202);
    pulse_tmr; idle; chk(chq.size(), 1);
    rd(A_RES); chk(v, dat(2));
    // reserved source code takes neither timer nor pin trigger
    chq.delete();
    wr(A_CTL, 32'h0); wr(A_TRG, 32'h1225); wr(A_CTL, 32'h1);
    pulse_tmr; pin_fall; repeat (30) @(posedge aclk);
    chk(chq.size(), 0);
    chk({29'h0, stime}, 32'h5);
    // left-justified result of one software conversion
    wr(A_CTL, 32'h0); wr(A_TRG, 32'h1287); wr(A_CTL, 32'h3); idle;
    rd(A_RES); chk(v, dat(2) << 6);
    // pin source, continuous 0..1, then abort mid conversion
    chq.delete();
    wr(A_CTL, 32'h0); wr(A_TRG, 32'h0877); wr(A_CTL, 32'h1);
    pin_fall;
    while (chq.size() < 5) @(posedge aclk);
    wr(A_CTL, 32'h01); repeat (50) @(posedge aclk);
    chk(chq.size(), 5);
    for (i = 0; i < 5; i = i + 1) chk(chq[i], i & 1);
    rd(A_RES); chk(v, dat(1));
    rd(A_CTL); chk(v & 32'h2, 32'h0);
    final_report;
  end
endmodule
